// >>> hdl/fwg_top.sv
// Command gate of the flash: write latch, power-up lockout, byte
// boundary check, block protection, lock modes and deep sleep.
// Assumes rst_b is the power-on reset and the host holds chip select
// high for at least eight system clocks between frames.
`timescale 1ns/10ps
module fwg_top
  import fwg_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC,
  parameter int OP_CYCLES  = OP_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              spi_clk,
  input  wire logic              spi_cs_b,
  input  wire logic              spi_di,
  input  wire logic              wp_b,
  input  wire logic [7:0]        array_rd_byte,
  output logic                   spi_do,
  output logic                   spi_do_oe_b,
  output logic                   rd_phase,
  output logic                   rd_next,
  output logic                   array_req_prog,
  output logic                   array_req_erase,
  output logic      [ADDR_W-1:0] array_op_addr,
  output logic      [4:0]        array_erase_shift,
  output logic                   array_erase_all,
  output logic      [7:0]        status_first,
  output logic      [7:0]        status_second,
  output logic      [7:0]        status_third,
  output logic                   deep_sleep_state,
  output logic                   power_up_write_delay_done,
  output logic                   cmd_ignored
);
  // ==========================================================
  // Protection decode
  localparam int PUW_W = $clog2(PUW_CYCLES + 1);
  localparam int OPC_W = $clog2(OP_CYCLES + 1);

  function automatic logic prot_hit(input logic [5:0] nv,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    logic [2:0]      bp;
    logic [ADDR_W:0] sz;
    logic [ADDR_W:0] plo;
    logic [ADDR_W:0] phi;
    int              sh;
    bp = nv[2:0];
    if (bp == BP_NONE) begin
      return 1'b0;
    end
    if (bp == BP_ALL) begin
      return 1'b1;
    end
    sh = nv[4] ? SECTOR_SH + int'(bp) - 1 : BLOCK_SH + int'(bp) - 1;
    if (nv[4] && sh > SEC_MAX_SH) begin
      sh = SEC_MAX_SH;
    end
    sz = (ADDR_W + 1)'(1) << sh;
    if (nv[3]) begin
      plo = '0;
      phi = sz - (ADDR_W + 1)'(1);
    end else begin
      plo = ((ADDR_W + 1)'(1) << ADDR_W) - sz;
      phi = ((ADDR_W + 1)'(1) << ADDR_W) - (ADDR_W + 1)'(1);
    end
    return ({1'b0, lo} <= phi) && ({1'b0, hi} >= plo);
  endfunction : prot_hit

  // ==========================================================
  // Crossings
  logic [1:0]        pin_s;
  logic              cs_s, wp_s;
  logic [LC_W-1:0]   lc_link;
  logic [7:0]        f_op;
  logic [ADDR_W-1:0] f_addr;
  logic [7:0]        f_d0, f_d1;
  logic [CNT_W-1:0]  f_bits;

  fwg_sync #(.W(2), .RST(2'h3)) u_pin_sync (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     ({spi_cs_b, wp_b}),
    .q     (pin_s)
  );
  assign cs_s = pin_s[1];
  assign wp_s = pin_s[0];

  fwg_sync #(.W(LC_W), .RST(LC_RST)) u_lc_sync (
    .clk   (spi_clk),
    .rst_b (rst_b),
    .d     (status_third[LC_W-1:0]),
    .q     (lc_link)
  );

  fwg_link u_link (
    .spi_clk       (spi_clk),
    .rst_b         (rst_b),
    .spi_cs_b      (spi_cs_b),
    .spi_di        (spi_di),
    .lat_code      (lc_link),
    .array_rd_byte (array_rd_byte),
    .frame_op      (f_op),
    .frame_addr    (f_addr),
    .frame_d0      (f_d0),
    .frame_d1      (f_d1),
    .frame_bits    (f_bits),
    .spi_do        (spi_do),
    .spi_do_oe_b   (spi_do_oe_b),
    .rd_phase      (rd_phase),
    .rd_next       (rd_next)
  );

  // ==========================================================
  // Command state
  fwg_op_e           st_r, st_nxt;
  logic [OPC_W-1:0]  opc_r, opc_nxt;
  logic [PUW_W-1:0]  puw_r, puw_nxt;
  logic              puw_done_nxt;
  logic              cs_prev_r;
  logic [5:0]        nv_r, nv_nxt;
  logic              lock_high_r, lock_high_nxt;
  logic [LC_W-1:0]   lc_r, lc_nxt;
  logic              wl_r, wl_nxt;
  logic              sleep_nxt;
  logic              rst_en_r, rst_en_nxt;
  logic              prog_nxt, erase_nxt, all_nxt, ign_nxt;
  logic [ADDR_W-1:0] addr_nxt, lo, hi;
  logic [4:0]        esh_nxt;
  logic              frame_end, byte_ok, wr_ok, sr_locked, idle;
  logic [1:0]        lock_mode;
  logic [CNT_W-1:0]  nbytes;
  int                sh;

  assign lock_mode     = {lock_high_r, nv_r[5]};
  assign status_first  = {nv_r, wl_r, st_r == FWG_BUSY};
  assign status_second = {7'h00, lock_high_r};
  assign status_third  = {4'h0, lc_r};

  always_comb begin
    st_nxt        = st_r;
    opc_nxt       = opc_r;
    puw_nxt       = puw_r;
    puw_done_nxt  = power_up_write_delay_done;
    nv_nxt        = nv_r;
    lock_high_nxt = lock_high_r;
    lc_nxt        = lc_r;
    wl_nxt        = wl_r;
    sleep_nxt     = deep_sleep_state;
    rst_en_nxt    = rst_en_r;
    prog_nxt      = 1'b0;
    erase_nxt     = 1'b0;
    all_nxt       = array_erase_all;
    ign_nxt       = 1'b0;
    addr_nxt      = array_op_addr;
    esh_nxt       = array_erase_shift;
    sh            = SECTOR_SH;
    lo            = '0;
    hi            = '1;
    idle          = (st_r == FWG_IDLE);
    frame_end     = cs_s && !cs_prev_r;
    byte_ok       = (f_bits[2:0] == 3'h0) && (f_bits != '0);
    nbytes        = f_bits >> 3;
    wr_ok         = byte_ok && wl_r && power_up_write_delay_done && idle;
    sr_locked     = (lock_mode == LOCK_PIN) ? !wp_s : (lock_mode != LOCK_SW);

    if (!power_up_write_delay_done) begin
      puw_nxt = puw_r + PUW_W'(1);
      if (puw_r == PUW_W'(PUW_CYCLES - 1)) begin
        puw_done_nxt = 1'b1;
      end
    end

    if (!idle) begin
      opc_nxt = opc_r + OPC_W'(1);
      if (opc_r == OPC_W'(OP_CYCLES - 1)) begin
        st_nxt = FWG_IDLE;
        wl_nxt = 1'b0;
      end
    end

    if (frame_end && f_bits >= CNT_W'(BYTE_BITS)) begin
      rst_en_nxt = 1'b0;
      if (deep_sleep_state) begin
        if (f_op == OP_WAKE) begin
          sleep_nxt = 1'b0;
        end else begin
          ign_nxt = 1'b1;
        end
      end else begin
        case (f_op)
          OP_WREN: begin
            if (byte_ok && idle && power_up_write_delay_done) begin
              wl_nxt = 1'b1;
            end else begin
              ign_nxt = 1'b1;
            end
          end
          OP_WRDI: begin
            if (byte_ok && idle) begin
              wl_nxt = 1'b0;
            end
          end
          OP_WRSR: begin
            if (wr_ok && !sr_locked && nbytes >= CNT_W'(NB_SR1)) begin
              nv_nxt = f_d0[7:2];
              if (nbytes >= CNT_W'(NB_SR2)) begin
                lock_high_nxt = f_d1[0];
              end
              st_nxt  = FWG_BUSY;
              opc_nxt = '0;
            end else begin
              ign_nxt = 1'b1;
            end
          end
          OP_WRSR3: begin
            if (byte_ok && wl_r && idle && nbytes >= CNT_W'(NB_SR1)) begin
              lc_nxt = f_d0[LC_W-1:0];
              wl_nxt = 1'b0;
            end else begin
              ign_nxt = 1'b1;
            end
          end
          OP_PP, OP_SE, OP_BE, OP_CE1, OP_CE2: begin
            if (f_op == OP_PP) begin
              sh = PAGE_SH;
            end else if (f_op == OP_BE) begin
              sh = BLOCK_SH;
            end
            if (f_op == OP_CE1 || f_op == OP_CE2) begin
              lo = '0;
              hi = '1;
            end else begin
              lo = (f_addr >> sh) << sh;
              hi = lo | ((ADDR_W'(1) << sh) - ADDR_W'(1));
            end
            if (wr_ok && !prot_hit(nv_r, lo, hi) &&
                ((f_op == OP_PP && nbytes >= CNT_W'(NB_PP)) ||
                 ((f_op == OP_SE || f_op == OP_BE) && nbytes >= CNT_W'(NB_ADDR)) ||
                 f_op == OP_CE1 || f_op == OP_CE2)) begin
              st_nxt    = FWG_BUSY;
              opc_nxt   = '0;
              addr_nxt  = lo;
              prog_nxt  = (f_op == OP_PP);
              erase_nxt = (f_op != OP_PP);
              all_nxt   = (f_op == OP_CE1 || f_op == OP_CE2);
              esh_nxt   = 5'(sh);
            end else begin
              ign_nxt = 1'b1;
            end
          end
          OP_SLEEP: begin
            if (idle) begin
              sleep_nxt = 1'b1;
            end
          end
          OP_RST_EN: rst_en_nxt = 1'b1;
          OP_RST: begin
            if (rst_en_r && idle) begin
              wl_nxt = 1'b0;
              lc_nxt = LC_RST;
              if (lock_mode == LOCK_DOWN) begin
                nv_nxt[5]     = 1'b0;
                lock_high_nxt = 1'b0;
              end
            end
          end
          default: ign_nxt = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r                      <= FWG_IDLE;
      opc_r                     <= '0;
      puw_r                     <= '0;
      power_up_write_delay_done <= 1'b0;
      cs_prev_r                 <= 1'b1;
      nv_r                      <= NV_RST;
      lock_high_r               <= 1'b0;
      lc_r                      <= LC_RST;
      wl_r                      <= 1'b0;
      deep_sleep_state          <= 1'b0;
      rst_en_r                  <= 1'b0;
      array_req_prog            <= 1'b0;
      array_req_erase           <= 1'b0;
      array_erase_all           <= 1'b0;
      cmd_ignored               <= 1'b0;
      array_op_addr             <= '0;
      array_erase_shift         <= '0;
    end else begin
      st_r                      <= st_nxt;
      opc_r                     <= opc_nxt;
      puw_r                     <= puw_nxt;
      power_up_write_delay_done <= puw_done_nxt;
      cs_prev_r                 <= cs_s;
      nv_r                      <= nv_nxt;
      lock_high_r               <= lock_high_nxt;
      lc_r                      <= lc_nxt;
      wl_r                      <= wl_nxt;
      deep_sleep_state          <= sleep_nxt;
      rst_en_r                  <= rst_en_nxt;
      array_req_prog            <= prog_nxt;
      array_req_erase           <= erase_nxt;
      array_erase_all           <= all_nxt;
      cmd_ignored               <= ign_nxt;
      array_op_addr             <= addr_nxt;
      array_erase_shift         <= esh_nxt;
    end
  end
endmodule : fwg_top

// >>> common/fwg_pkg.sv
// Constants shared by the flash write guard and read latency logic.
// Assumes a single-lane SPI host and a 100 MHz system clock.
package fwg_pkg;
  localparam int          ADDR_W       = 22;
  localparam int          CNT_W        = 12;
  localparam int          CLK_MHZ      = 100;
  localparam int          PUW_US       = 5000;
  localparam int          PUW_CYC      = PUW_US * CLK_MHZ;
  localparam int          OP_CYC       = 1000;
  localparam logic [7:0]  OP_READ      = 8'h03;
  localparam logic [7:0]  OP_FAST      = 8'h0B;
  localparam logic [7:0]  OP_DUAL_OUT  = 8'h3B;
  localparam logic [7:0]  OP_QUAD_OUT  = 8'h6B;
  localparam logic [7:0]  OP_DUAL_IO   = 8'hBB;
  localparam logic [7:0]  OP_QUAD_IO   = 8'hEB;
  localparam logic [7:0]  OP_WORD_QIO  = 8'hE7;
  localparam logic [7:0]  OP_WREN      = 8'h06;
  localparam logic [7:0]  OP_WRDI      = 8'h04;
  localparam logic [7:0]  OP_WRSR      = 8'h01;
  localparam logic [7:0]  OP_WRSR3     = 8'h11;
  localparam logic [7:0]  OP_PP        = 8'h02;
  localparam logic [7:0]  OP_SE        = 8'h20;
  localparam logic [7:0]  OP_BE        = 8'hD8;
  localparam logic [7:0]  OP_CE1       = 8'hC7;
  localparam logic [7:0]  OP_CE2       = 8'h60;
  localparam logic [7:0]  OP_SLEEP     = 8'hB9;
  localparam logic [7:0]  OP_WAKE      = 8'hAB;
  localparam logic [7:0]  OP_RST_EN    = 8'h66;
  localparam logic [7:0]  OP_RST       = 8'h99;
  localparam int          BYTE_BITS    = 8;
  localparam int          ADDR_CLK_SPI = 24;
  localparam int          ADDR_CLK_DIO = 12;
  localparam int          ADDR_CLK_QIO = 6;
  localparam int          LEG_DUMMY    = 8;
  localparam int          MODE_DIO     = 4;
  localparam int          MODE_QIO     = 2;
  localparam int          DUMMY_QIO    = 4;
  localparam int          DUMMY_WQIO   = 2;
  localparam int          LC_W         = 4;
  localparam logic [3:0]  LC_RST       = 4'h0;
  localparam logic [5:0]  NV_RST       = 6'h00;
  localparam logic [2:0]  BP_NONE      = 3'h0;
  localparam logic [2:0]  BP_ALL       = 3'h7;
  localparam int          PAGE_SH      = 8;
  localparam int          SECTOR_SH    = 12;
  localparam int          BLOCK_SH     = 16;
  localparam int          SEC_MAX_SH   = 15;
  localparam int          NB_ADDR      = 4;
  localparam int          NB_PP        = 5;
  localparam int          NB_SR1       = 2;
  localparam int          NB_SR2       = 3;
  localparam logic [1:0]  LOCK_SW      = 2'h0;
  localparam logic [1:0]  LOCK_PIN     = 2'h1;
  localparam logic [1:0]  LOCK_DOWN    = 2'h2;
  typedef enum logic {FWG_IDLE, FWG_BUSY} fwg_op_e;
endpackage : fwg_pkg

// >>> hdl/fwg_sync.sv
// Three-flop synchroniser for levels or quasi-static words.
// Assumes the source only changes slowly against the sampling clock.
`timescale 1ns/10ps
module fwg_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // ==========================================================
  // Stages
  logic [W-1:0] s1_r, s2_r, s3_r, q_nxt;
  always_comb begin
    q_nxt = (s2_r == s3_r) ? s3_r : q;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q    <= RST;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
    end
  end
endmodule : fwg_sync

// >>> hdl/fwg_link.sv
// Serial side of the guard: shifts in command bytes, counts clocks,
// times the read latency and drives single-lane read data.
// Assumes the serial clock runs only while chip select is low.
`timescale 1ns/10ps
module fwg_link
  import fwg_pkg::*;
(
  input  wire logic              spi_clk,
  input  wire logic              rst_b,
  input  wire logic              spi_cs_b,
  input  wire logic              spi_di,
  input  wire logic [LC_W-1:0]   lat_code,
  input  wire logic [7:0]        array_rd_byte,
  output logic      [7:0]        frame_op,
  output logic      [ADDR_W-1:0] frame_addr,
  output logic      [7:0]        frame_d0,
  output logic      [7:0]        frame_d1,
  output logic      [CNT_W-1:0]  frame_bits,
  output logic                   spi_do,
  output logic                   spi_do_oe_b,
  output logic                   rd_phase,
  output logic                   rd_next
);
  // ==========================================================
  // Read timing per opcode
  function automatic logic [CNT_W-1:0] data_start(input logic [7:0] op,
                                                  input logic [LC_W-1:0] lc);
    int a;
    int m;
    int d;
    a = ADDR_CLK_SPI;
    m = 0;
    d = LEG_DUMMY;
    case (op)
      OP_READ:     d = 0;
      OP_DUAL_IO:  begin a = ADDR_CLK_DIO; m = MODE_DIO; d = 0; end
      OP_QUAD_IO:  begin a = ADDR_CLK_QIO; m = MODE_QIO; d = DUMMY_QIO; end
      OP_WORD_QIO: begin a = ADDR_CLK_QIO; m = MODE_QIO; d = DUMMY_WQIO; end
      default:     d = LEG_DUMMY;
    endcase
    if (op != OP_READ && lc != LC_RST) begin
      d = int'(lc);
    end
    return CNT_W'(BYTE_BITS + a + m + d + 1);
  endfunction : data_start

  function automatic logic is_read(input logic [7:0] op);
    return op inside {OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT,
                      OP_DUAL_IO, OP_QUAD_IO, OP_WORD_QIO};
  endfunction : is_read

  // ==========================================================
  // Frame state
  logic              frame_rst_b;
  logic              live_r, live_nxt;
  logic [7:0]        sh_nxt;
  logic [CNT_W-1:0]  cnt_nxt, start, idx;
  logic [7:0]        op_nxt, d0_nxt, d1_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic              do_nxt, ph_nxt, single;
  logic [7:0]        sh_r;

  assign frame_rst_b = rst_b & ~spi_cs_b;
  assign single      = (frame_op == OP_READ) || (frame_op == OP_FAST);
  assign rd_next     = rd_phase && (idx[2:0] == 3'h7);

  always_comb begin
    live_nxt = 1'b1;
    sh_nxt   = {sh_r[6:0], spi_di};
    cnt_nxt  = live_r ? frame_bits + CNT_W'(1) : CNT_W'(1);
    if (live_r && frame_bits == '1) begin
      cnt_nxt = frame_bits;
    end
    op_nxt   = (cnt_nxt == CNT_W'(BYTE_BITS)) ? sh_nxt : frame_op;
    addr_nxt = frame_addr;
    if (cnt_nxt > CNT_W'(BYTE_BITS) && cnt_nxt <= CNT_W'(ADDR_CLK_SPI + BYTE_BITS)) begin
      addr_nxt = {frame_addr[ADDR_W-2:0], spi_di};
    end
    d0_nxt = (cnt_nxt == CNT_W'(BYTE_BITS * NB_SR1)) ? sh_nxt : frame_d0;
    d1_nxt = (cnt_nxt == CNT_W'(BYTE_BITS * NB_SR2)) ? sh_nxt : frame_d1;
    start  = data_start(frame_op, lat_code);
    idx    = cnt_nxt - start;
    ph_nxt = (cnt_nxt > CNT_W'(BYTE_BITS)) && is_read(frame_op) && (cnt_nxt >= start);
    do_nxt = ph_nxt ? array_rd_byte[3'h7 - idx[2:0]] : 1'b0;
  end

  always_ff @(posedge spi_clk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      live_r      <= 1'b0;
      rd_phase    <= 1'b0;
      spi_do      <= 1'b0;
      spi_do_oe_b <= 1'b1;
    end else begin
      live_r      <= live_nxt;
      rd_phase    <= ph_nxt;
      spi_do      <= do_nxt;
      spi_do_oe_b <= ~(ph_nxt && single);
    end
  end

  always_ff @(posedge spi_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r       <= '0;
      frame_bits <= '0;
      frame_op   <= '0;
      frame_addr <= '0;
      frame_d0   <= '0;
      frame_d1   <= '0;
    end else begin
      sh_r       <= sh_nxt;
      frame_bits <= cnt_nxt;
      frame_op   <= op_nxt;
      frame_addr <= addr_nxt;
      frame_d0   <= d0_nxt;
      frame_d1   <= d1_nxt;
    end
  end
endmodule : fwg_link

// >>> testbench/fwg_top_monitor.sv
// Checker of the write guard top ports: lockout, latch, busy, sleep.
// Bound to every fwg_top instance; sees its ports only.
`timescale 1ns/10ps
module fwg_top_monitor
  import fwg_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC,
  parameter int OP_CYCLES  = OP_CYC
) (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       spi_clk,
  input wire logic       spi_do_oe_b,
  input wire logic       rd_phase,
  input wire logic       array_req_prog,
  input wire logic       array_req_erase,
  input wire logic [7:0] status_first,
  input wire logic [7:0] status_second,
  input wire logic       deep_sleep_state,
  input wire logic       power_up_write_delay_done,
  input wire logic       cmd_ignored
);
  // ==========================================
  // Cycle counters
  int up_r;
  int up_nxt;
  int busy_r;
  int busy_nxt;
  always_comb begin
    up_nxt   = (up_r < PUW_CYCLES + 8) ? up_r + 1 : up_r;
    busy_nxt = status_first[0] ? busy_r + 1 : 0;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      up_r   <= 0;
      busy_r <= 0;
    end else begin
      up_r   <= up_nxt;
      busy_r <= busy_nxt;
    end
  end
  // ==========================================
  // Properties
  sequence s_op_end;
    $fell(status_first[0]);
  endsequence
  sequence s_req;
    array_req_prog || array_req_erase;
  endsequence
  AST_PUW_EARLY : assert property (@(posedge clk_sys) disable iff (!rst_b)
    power_up_write_delay_done == (up_r >= PUW_CYCLES)) else $error("delay ended early");
  AST_PUW_GATE : assert property (@(posedge clk_sys) disable iff (!rst_b)
    !power_up_write_delay_done |-> !status_first[1] && !array_req_prog && !array_req_erase)
    else $error("write accepted in delay");
  AST_PROG_LATCH : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_req |-> $past(status_first[1]) && !$past(status_first[0]) && status_first[0]) else $error("op without latch");
  AST_OP_END : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_op_end |-> !status_first[1] && busy_r == OP_CYCLES) else $error("op end wrong");
  AST_SLEEP : assert property (@(posedge clk_sys) disable iff (!rst_b)
    deep_sleep_state && $past(deep_sleep_state) |-> !array_req_prog && !array_req_erase && $stable(status_first))
    else $error("activity asleep");
  AST_LOCKDOWN : assert property (@(posedge clk_sys) disable iff (!rst_b)
    status_second[0] && !status_first[7] |=> $stable(status_first[7:2]) || !status_second[0])
    else $error("locked status changed");
  AST_IGNORED : assert property (@(posedge clk_sys) disable iff (!rst_b)
    cmd_ignored |-> $stable(status_first[7:2]) && $stable(status_second) && !array_req_prog)
    else $error("ignored command had effect");
  AST_REQ_PULSE : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_req |=> !array_req_prog && !array_req_erase) else $error("request longer than one cycle");
  AST_RD_OE : assert property (@(posedge spi_clk) disable iff (!rst_b)
    $fell(spi_do_oe_b) |-> rd_phase) else $error("drive outside data phase");
endmodule : fwg_top_monitor

bind fwg_top fwg_top_monitor #(.PUW_CYCLES(PUW_CYCLES), .OP_CYCLES(OP_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .spi_clk(spi_clk), .spi_do_oe_b(spi_do_oe_b), .rd_phase(rd_phase),
  .array_req_prog(array_req_prog), .array_req_erase(array_req_erase), .status_first(status_first),
  .status_second(status_second), .deep_sleep_state(deep_sleep_state),
  .power_up_write_delay_done(power_up_write_delay_done), .cmd_ignored(cmd_ignored)
);

// >>> testbench/fwg_host.sv
// Host model: single-lane serial clock, chip select and data in.
// The testbench starts frames through the frame task.
`timescale 1ns/10ps
module fwg_host (
  output logic spi_clk,
  output logic spi_cs_b,
  output logic spi_di
);
  initial begin
    spi_clk  = 1'b0;
    spi_cs_b = 1'b1;
    spi_di   = 1'b1;
  end
  // ==========================================
  // Frame: nb bits MSB first, ex further clocks; clock still between frames
  task automatic frame(input logic [63:0] b, input int nb, input int ex);
    #3.3 spi_cs_b = 1'b0;
    for (int i = 0; i < nb + ex; i++) begin
      spi_di = (i < nb) ? b[63 - i] : ~spi_di;
      #40 spi_clk = 1'b1;
      #40 spi_clk = 1'b0;
    end
    #40 spi_cs_b = 1'b1;
    spi_di = ~spi_di;
    #200;
  endtask : frame
endmodule : fwg_host

// >>> testbench/fwg_top_tb_top.sv
// Self-checking bench of the flash write guard with a host model.
// Runs the guard with short power-up and operation counts.
`timescale 1ns/10ps
module fwg_top_tb_top;
  import fwg_pkg::*;
  localparam int PUW_N = 200;
  localparam int OP_N  = 10;
  logic              clk_sys, rst_b, wp_b, spi_clk, spi_cs_b, spi_di, spi_do, spi_do_oe_b, rd_phase, rd_next;
  logic [7:0]        array_rd_byte, status_first, status_second, status_third, r, rd_b;
  logic [ADDR_W-1:0] array_op_addr, addr;
  logic [4:0]        array_erase_shift;
  logic              array_req_prog, array_req_erase, array_erase_all, deep_sleep_state, cmd_ignored;
  logic              power_up_write_delay_done;
  int                n_fail, check_count, n_prog, n_er, n_ign, clk_n, first_oe, lat;
  fwg_top #(.PUW_CYCLES(PUW_N), .OP_CYCLES(OP_N)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_di(spi_di), .wp_b(wp_b),
    .array_rd_byte(array_rd_byte), .spi_do(spi_do), .spi_do_oe_b(spi_do_oe_b), .rd_phase(rd_phase),
    .rd_next(rd_next), .array_req_prog(array_req_prog), .array_req_erase(array_req_erase),
    .array_op_addr(array_op_addr), .array_erase_shift(array_erase_shift), .array_erase_all(array_erase_all),
    .status_first(status_first), .status_second(status_second), .status_third(status_third),
    .deep_sleep_state(deep_sleep_state), .power_up_write_delay_done(power_up_write_delay_done),
    .cmd_ignored(cmd_ignored)
  );
  fwg_host host (.spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_di(spi_di));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (array_req_prog === 1'b1) n_prog++;
    if (array_req_erase === 1'b1) n_er++;
    if (cmd_ignored === 1'b1) n_ign++;
  end
  always @(posedge spi_clk or posedge spi_cs_b) begin
    if (spi_cs_b) clk_n = 0;
    else clk_n++;
  end
  always @(negedge spi_clk) begin
    if (spi_do_oe_b === 1'b0 && first_oe == 0) first_oe = clk_n;
    if (spi_do_oe_b === 1'b0 && clk_n < first_oe + 8) rd_b = {rd_b[6:0], spi_do};
  end
  // ==========================================
  // Helpers
  function automatic int exp_start(input logic [7:0] op, input int lc);
    if (op == OP_READ) return 33;
    return 33 + ((lc == 0) ? LEG_DUMMY : lc);
  endfunction : exp_start
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tx(input logic [7:0] op, input logic [55:0] pl, input int nb, input int ex = 0);
    @(negedge clk_sys);
    host.frame({op, pl}, nb, ex);
  endtask : tx
  task automatic tally_and_finish;
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(32'h0000_6729));
    {n_fail, check_count, n_prog, n_er, n_ign, first_oe} = '0;
    rst_b = 1'b0;
    wp_b = 1'b1;
    array_rd_byte = 8'($urandom);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    chk("status_first", status_first, 8'h00);
    chk("status_third", status_third, 8'h00);
    tx(OP_WREN, '0, 8);
    chk("latch early", status_first[1], 1'b0);
    chk("refusals", n_ign, 1);
    for (int i = 0; i < PUW_N && power_up_write_delay_done !== 1'b1; i++) @(negedge clk_sys);
    chk("delay done", power_up_write_delay_done, 1'b1);
    if (power_up_write_delay_done !== 1'b1) tally_and_finish();
    tx(OP_WREN, '0, 9);
    chk("latch partial", status_first[1], 1'b0);
    tx(OP_WREN, '0, 8);
    chk("latch set", status_first[1], 1'b1);
    addr = ADDR_W'($urandom);
    tx(OP_PP, {2'b00, addr, 8'($urandom), 24'h00_0000}, 41);
    chk("prog partial", n_prog, 0);
    chk("latch kept", status_first[1], 1'b1);
    tx(OP_PP, {2'b00, addr, 8'($urandom), 24'h00_0000}, 40);
    chk("prog", n_prog, 1);
    chk("prog addr", array_op_addr, {addr[21:8], 8'h00});
    chk("latch after op", status_first[1:0], 2'b00);
    tx(OP_PP, {2'b00, addr, 32'h0000_0000}, 40);
    chk("prog no latch", n_prog, 1);
    r = 8'($urandom) | 8'h1C;
    r[7] = 1'b0;
    tx(OP_WREN, '0, 8);
    tx(OP_WRSR, {r, 48'h0000_0000_0000}, 16);
    chk("status write", status_first, {r[7:2], 2'b00});
    tx(OP_WREN, '0, 8);
    tx(OP_PP, {2'b00, addr, 32'h0000_0000}, 40);
    chk("prog protected", n_prog, 1);
    chk("latch on refusal", status_first[1], 1'b1);
    tx(OP_WRSR, {8'h80, 48'h0000_0000_0000}, 16);
    chk("pin mode", status_first, 8'h80);
    @(negedge clk_sys) wp_b = 1'b0;
    tx(OP_WREN, '0, 8);
    tx(OP_WRSR, '0, 16);
    chk("pin lock", status_first, 8'h82);
    @(negedge clk_sys) wp_b = 1'b1;
    tx(OP_WRSR, '0, 16);
    chk("pin free", status_first, 8'h00);
    tx(OP_WREN, '0, 8);
    tx(OP_SE, {2'b00, addr, 32'h0000_0000}, 32);
    chk("erase", {n_er[25:0], array_erase_all, array_erase_shift}, {26'h1, 1'b0, 5'(SECTOR_SH)});
    tx(OP_WREN, '0, 8);
    tx(OP_WRSR, {16'h0001, 40'h00_0000_0000}, 24);
    chk("lockdown", status_second, 8'h01);
    tx(OP_WREN, '0, 8);
    tx(OP_WRSR, {8'h1C, 48'h0000_0000_0000}, 16);
    chk("locked", status_first, 8'h02);
    tx(OP_RST_EN, '0, 8);
    tx(OP_RST, '0, 8);
    chk("lock cleared", {status_second, status_first}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      lat = (k == 0) ? 0 : (k == 1) ? 15 : 1 + $urandom % 15;
      tx(OP_WREN, '0, 8);
      tx(OP_WRSR3, {4'h0, 4'(lat), 48'h0000_0000_0000}, 16);
      chk("latency field", status_third, 8'(lat));
      for (int m = 0; m < 2; m++) begin
        first_oe = 0;
        tx(m ? OP_READ : OP_FAST, {2'b00, addr, 32'h0000_0000}, 32, 26);
        chk("data start", first_oe, exp_start(m ? OP_READ : OP_FAST, lat));
        chk("read data", rd_b, array_rd_byte);
      end
    end
    tx(OP_SLEEP, '0, 8);
    chk("sleep", deep_sleep_state, 1'b1);
    tx(OP_WREN, '0, 8);
    chk("latch asleep", status_first[1], 1'b0);
    tx(OP_WAKE, '0, 8);
    chk("awake", deep_sleep_state, 1'b0);
    tally_and_finish();
  end
endmodule : fwg_top_tb_top
